// file: core/i2c_seq_host.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module i2c_seq_host
    import i2c_seq_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic      [11:0] dev_addr,
    output logic      [7:0]  dev_wdata,
    output logic             dev_wr,
    output logic             dev_rd,
    input  wire logic [7:0]  dev_rdata
);
    localparam int IW = $clog2(DEPTH);
    localparam int CW = IW + 1;

    seq_state_t     state_q;
    seq_state_t     state_d;
    logic [11:0]    dev_addr_q;
    logic [11:0]    dev_addr_d;
    logic [7:0]     dev_wdata_q;
    logic [7:0]     dev_wdata_d;
    logic           dev_wr_q;
    logic           dev_wr_d;
    logic           dev_rd_q;
    logic           dev_rd_d;
    logic [15:0]    rdata_q;
    logic [9:0]     slave_q;
    logic [CW-1:0]  len_q;
    logic           read_q;
    logic           ten_q;
    logic           done_q;
    logic           nack_q;
    logic [CW-1:0]  tx_cnt_q;
    logic [CW-1:0]  rx_cnt_q;
    logic [7:0]     buf_q [DEPTH];

    wire            busy       = (state_q != S_IDLE);
    wire            go_take    = wr && (addr == REG_CMD) && wdata[CMD_GO] && !busy;
    wire            buf_hit    = (addr >= REG_BUF) && (addr < REG_BUF + 8'(DEPTH));
    wire [IW-1:0]   buf_idx    = IW'(addr - REG_BUF);
    // A 10-bit read needs a repeated start sequence; ten-bit transfers are writes only.
    wire            rd_mode    = read_q && !ten_q;
    wire [CW-1:0]   len_eff    = (rd_mode && len_q == '0) ? CW'(1) : len_q;
    wire [CW-1:0]   tx_total   = len_q + CW'(ten_q);
    wire [IW-1:0]   tx_idx     = IW'(tx_cnt_q - CW'(ten_q));
    wire [7:0]      tx_byte    = (ten_q && tx_cnt_q == '0) ? slave_q[7:0] : buf_q[tx_idx];
    wire [7:0]      first_addr = ten_q ? {TEN_PREFIX, slave_q[9:8], 1'b0}
                                       : {slave_q[6:0], rd_mode};
    wire [CW-1:0]   rx_next    = rx_cnt_q + CW'(1);
    wire            nak_due    = (len_eff > CW'(1)) && (rx_next == len_eff - CW'(1));
    wire            st_empty   = dev_rdata[ST_HOLD_EMPTY];
    wire            st_rxfull  = dev_rdata[ST_RX_FULL];
    wire            st_nacki   = dev_rdata[ST_NACK_IRQ];
    wire [15:0]     stat_word  = {13'h0000, nack_q, done_q, busy};
    wire [15:0]     rd_word    = (addr == REG_SLAVE) ? {6'h00, slave_q}
                               : (addr == REG_LEN)   ? 16'(len_q)
                               : (addr == REG_STAT)  ? stat_word
                               : buf_hit             ? {8'h00, buf_q[buf_idx]}
                               : 16'h0000;

    always_comb begin
        state_d     = state_q;
        dev_wr_d    = 1'b0;
        dev_rd_d    = 1'b0;
        dev_addr_d  = dev_addr_q;
        dev_wdata_d = dev_wdata_q;
        case (state_q)
            S_IDLE: begin
                if (go_take) begin
                    state_d = S_ENABLE;
                end
            end
            S_ENABLE: begin
                dev_wr_d    = 1'b1;
                dev_addr_d  = DEV_CTL;
                dev_wdata_d = CTL_EN | CTL_TXI;
                state_d     = S_POLL_E;
            end
            S_POLL_E: begin
                dev_rd_d   = 1'b1;
                dev_addr_d = DEV_STAT;
                state_d    = S_WAIT_E;
            end
            S_WAIT_E: state_d = S_CHK_E;
            S_CHK_E: begin
                state_d = st_empty ? S_ADDR : S_POLL_E;
            end
            S_ADDR: begin
                dev_wr_d    = 1'b1;
                dev_addr_d  = DEV_DATA;
                dev_wdata_d = first_addr;
                state_d     = S_START;
            end
            S_START: begin
                dev_wr_d    = 1'b1;
                dev_addr_d  = DEV_CTL;
                dev_wdata_d = CTL_EN | CTL_START | (rd_mode ? 8'h00 : CTL_TXI)
                            | ((rd_mode && len_eff == CW'(1)) ? CTL_NAK : 8'h00);
                state_d     = S_POLL;
            end
            S_POLL: begin
                dev_rd_d   = 1'b1;
                dev_addr_d = DEV_STAT;
                state_d    = S_WAIT;
            end
            S_WAIT: state_d = S_CHK;
            S_CHK: begin
                // Polling simply spins while the slave stretches the clock.
                if (st_nacki) begin
                    state_d = S_STOP;
                end else if (rd_mode) begin
                    state_d = st_rxfull ? S_RXD : S_POLL;
                end else if (st_empty) begin
                    state_d = (tx_cnt_q < tx_total) ? S_TXD : S_STOP;
                end else begin
                    state_d = S_POLL;
                end
            end
            S_TXD: begin
                dev_wr_d    = 1'b1;
                dev_addr_d  = DEV_DATA;
                dev_wdata_d = tx_byte;
                state_d     = S_POLL;
            end
            S_RXD: begin
                dev_rd_d   = 1'b1;
                dev_addr_d = DEV_DATA;
                state_d    = S_RXW;
            end
            S_RXW: state_d = S_RXCAP;
            S_RXCAP: begin
                state_d = nak_due ? S_NAKSET : S_POLL;
            end
            S_NAKSET: begin
                dev_wr_d    = 1'b1;
                dev_addr_d  = DEV_CTL;
                dev_wdata_d = CTL_EN | CTL_NAK;
                state_d     = S_POLL;
            end
            S_STOP: begin
                dev_wr_d    = 1'b1;
                dev_addr_d  = DEV_CTL;
                dev_wdata_d = CTL_EN | CTL_STOP;
                state_d     = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q     <= S_IDLE;
            dev_addr_q  <= 12'h000;
            dev_wdata_q <= 8'h00;
            dev_wr_q    <= 1'b0;
            dev_rd_q    <= 1'b0;
        end else begin
            state_q     <= state_d;
            dev_addr_q  <= dev_addr_d;
            dev_wdata_q <= dev_wdata_d;
            dev_wr_q    <= dev_wr_d;
            dev_rd_q    <= dev_rd_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q  <= 16'h0000;
            slave_q  <= 10'h000;
            len_q    <= '0;
            read_q   <= 1'b0;
            ten_q    <= 1'b0;
            done_q   <= 1'b0;
            nack_q   <= 1'b0;
            tx_cnt_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            rdata_q <= rd ? rd_word : 16'h0000;
            if (go_take) begin
                read_q   <= wdata[CMD_READ];
                ten_q    <= wdata[CMD_TEN];
                done_q   <= 1'b0;
                nack_q   <= 1'b0;
                tx_cnt_q <= '0;
                rx_cnt_q <= '0;
            end
            if (wr && !busy && addr == REG_SLAVE) begin
                slave_q <= wdata[9:0];
            end
            if (wr && !busy && addr == REG_LEN) begin
                len_q <= wdata[CW-1:0];
            end
            if (state_q == S_TXD) begin
                tx_cnt_q <= tx_cnt_q + CW'(1);
            end
            if (state_q == S_RXCAP) begin
                rx_cnt_q <= rx_next;
            end
            if (state_q == S_CHK && st_nacki) begin
                nack_q <= 1'b1;
            end
            if (state_q == S_STOP) begin
                done_q <= 1'b1;
            end
        end
    end

    // The engine and software share one buffer; software writes are dropped while busy.
    always_ff @(posedge mclk) begin
        if (state_q == S_RXCAP) begin
            buf_q[IW'(rx_cnt_q)] <= dev_rdata;
        end else if (wr && !busy && buf_hit) begin
            buf_q[buf_idx] <= wdata[7:0];
        end
    end

    assign rdata     = rdata_q;
    assign dev_addr  = dev_addr_q;
    assign dev_wdata = dev_wdata_q;
    assign dev_wr    = dev_wr_q;
    assign dev_rd    = dev_rd_q;

    a_enable_first: assert property (
        @(posedge mclk) disable iff (sys_rst)
        go_take |-> ##2 (dev_wr_q && dev_addr_q == DEV_CTL && dev_wdata_q == (CTL_EN | CTL_TXI)))
        else $error("enable and transmit irq enable not written first");
    a_addr_dir: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_ADDR && !ten_q) |=> (dev_wr_q && dev_addr_q == DEV_DATA
            && dev_wdata_q == {slave_q[6:0], read_q}))
        else $error("seven bit address byte wrong");
    a_ten_prefix: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_ADDR && ten_q) |=> (dev_wdata_q[7:3] == TEN_PREFIX && !dev_wdata_q[0]))
        else $error("ten bit first byte pattern wrong");
    a_second_addr: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_TXD && ten_q && tx_cnt_q == '0) |=> (dev_wdata_q == slave_q[7:0]))
        else $error("second address byte not sent first");
    a_stop_no_txi: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (dev_wr_q && dev_addr_q == DEV_CTL && dev_wdata_q[CTL_STOP_BIT]) |->
            (!dev_wdata_q[CTL_TXI_BIT] && $past(state_q) == S_STOP))
        else $error("stop written with transmit irq enable");
    a_nacki_stop: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_CHK && st_nacki) |-> ##2 (dev_wr_q && dev_addr_q == DEV_CTL
            && dev_wdata_q[CTL_STOP_BIT]))
        else $error("no stop after not-acknowledge irq");
    a_nak_single: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_START && rd_mode && len_eff == CW'(1)) |=> dev_wdata_q[CTL_NAK_BIT])
        else $error("single byte read lacks not-acknowledge request");
    a_rx_collect: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_CHK && rd_mode && st_rxfull && !st_nacki) |->
            ##2 (dev_rd_q && dev_addr_q == DEV_DATA) ##1 (state_q == S_RXCAP))
        else $error("received byte not collected");
    a_stop_empty: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_CHK && !rd_mode && !st_nacki && st_empty && tx_cnt_q == tx_total) |->
            ##2 (dev_wr_q && dev_wdata_q == (CTL_EN | CTL_STOP)))
        else $error("no stop when data ran out");
    // Strobes are registered, so each access shows one edge after the state that asks.
    a_start_follows: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_ADDR) |-> ##2 (dev_wr_q && dev_addr_q == DEV_CTL
            && (dev_wdata_q & CTL_START) != 8'h00))
        else $error("start not requested after address byte");
    a_read_dir: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_ADDR && rd_mode) |=> (dev_wr_q && dev_addr_q == DEV_DATA
            && dev_wdata_q[0]))
        else $error("read address byte lacks read bit");
    a_txi_write: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_START && !rd_mode) |=> dev_wdata_q[CTL_TXI_BIT])
        else $error("write start lacks transmit irq enable");
    a_read_no_txi: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_START && rd_mode) |=> !dev_wdata_q[CTL_TXI_BIT])
        else $error("read start keeps transmit irq enable");
    a_stall_poll: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_CHK && !rd_mode && !st_nacki && !st_empty) |=> (state_q == S_POLL))
        else $error("write went on before holding register emptied");
    a_ack_advance: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_CHK && !rd_mode && !st_nacki && st_empty && tx_cnt_q < tx_total) |->
            ##2 (dev_wr_q && dev_addr_q == DEV_DATA))
        else $error("next byte not loaded after acknowledge");
    a_rx_wait: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_CHK && rd_mode && !st_nacki && !st_rxfull) |=> (state_q == S_POLL))
        else $error("read went on before a byte arrived");
    a_nak_early: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_RXCAP && nak_due) |-> ##2 (dev_wr_q && dev_addr_q == DEV_CTL
            && dev_wdata_q[CTL_NAK_BIT]))
        else $error("not-acknowledge not requested before last byte");
    a_done_flag: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == S_STOP) |=> (state_q == S_IDLE && done_q))
        else $error("done not flagged after stop");
endmodule // i2c_seq_host
`default_nettype wire

// file: core/i2c_seq_pkg.sv
package i2c_seq_pkg;
    localparam logic [11:0] DEV_DATA = 12'hf50;
    localparam logic [11:0] DEV_STAT = 12'hf51;
    localparam logic [11:0] DEV_CTL  = 12'hf52;

    localparam logic [7:0] CTL_EN    = 8'h80;
    localparam logic [7:0] CTL_START = 8'h40;
    localparam logic [7:0] CTL_STOP  = 8'h20;
    localparam logic [7:0] CTL_TXI   = 8'h08;
    localparam logic [7:0] CTL_NAK   = 8'h04;

    localparam int ST_HOLD_EMPTY = 7;
    localparam int ST_RX_FULL    = 6;
    localparam int ST_NACK_IRQ   = 0;
    localparam int CTL_STOP_BIT  = 5;
    localparam int CTL_TXI_BIT   = 3;
    localparam int CTL_NAK_BIT   = 2;

    localparam logic [4:0] TEN_PREFIX = 5'h1e;

    localparam logic [7:0] REG_CMD   = 8'h00;
    localparam logic [7:0] REG_SLAVE = 8'h01;
    localparam logic [7:0] REG_LEN   = 8'h02;
    localparam logic [7:0] REG_STAT  = 8'h03;
    localparam logic [7:0] REG_BUF   = 8'h10;

    localparam int CMD_GO   = 0;
    localparam int CMD_READ = 1;
    localparam int CMD_TEN  = 2;

    typedef enum logic [3:0] {
        S_IDLE, S_ENABLE, S_POLL_E, S_WAIT_E, S_CHK_E, S_ADDR, S_START, S_POLL,
        S_WAIT, S_CHK, S_TXD, S_RXD, S_RXW, S_RXCAP, S_NAKSET, S_STOP
    } seq_state_t;
endpackage

// file: testbench/i2c_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_dev_model
    import i2c_seq_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] dev_addr,
    input  wire logic [7:0]  dev_wdata,
    input  wire logic        dev_wr,
    input  wire logic        dev_rd,
    output logic      [7:0]  dev_rdata,
    input  wire logic        slow,
    input  wire logic [3:0]  nak_at
);
    logic [7:0] ctl_q, data_q, last_ctl, rx_n;
    logic       empty_q, rxf_q, nck_q, act_q, first_q, rdm_q, nakm_q;
    int         cnt;
    logic [7:0] tx_q[$];
    // A stretching slave is modelled as a longer byte time, not as a held clock line.
    always @(posedge mclk) begin
        if (sys_rst) begin
            {ctl_q, data_q, last_ctl, rx_n} <= '0;
            {rxf_q, nck_q, act_q, first_q, rdm_q, nakm_q} <= '0;
            empty_q <= 1'b1;
            dev_rdata <= 8'h00;
            cnt <= 0;
        end else begin
            dev_rdata <= ~dev_rdata;
            if (act_q && !nck_q && !rxf_q) begin
                cnt <= (cnt == 0) ? (slow ? 60 : 12) : cnt - 1;
                if (cnt == 0 && first_q) begin
                    tx_q.push_back(data_q);
                    rdm_q <= data_q[0];
                    first_q <= 1'b0;
                    empty_q <= 1'b1;
                end else if (cnt == 0 && rdm_q) begin
                    data_q <= 8'h81 + rx_n;
                    rx_n <= rx_n + 8'h01;
                    rxf_q <= 1'b1;
                    nakm_q <= ctl_q[CTL_NAK_BIT];
                end else if (cnt == 0 && !empty_q) begin
                    tx_q.push_back(data_q);
                    empty_q <= 1'b1;
                    nck_q <= (tx_q.size() == int'(nak_at));
                end
            end
            if (dev_rd && dev_addr == DEV_DATA) begin
                dev_rdata <= data_q;
                rxf_q <= 1'b0;
                nck_q <= nakm_q;
            end
            if (dev_rd && dev_addr == DEV_STAT) begin
                dev_rdata <= {empty_q, rxf_q, 5'h00, nck_q};
            end
            if (dev_wr && dev_addr == DEV_DATA) begin
                data_q <= dev_wdata;
                empty_q <= 1'b0;
            end
            if (dev_wr && dev_addr == DEV_CTL) begin
                ctl_q <= dev_wdata;
                last_ctl <= dev_wdata;
                if (dev_wdata[6] || dev_wdata[5] || !dev_wdata[7]) begin
                    nck_q <= 1'b0;
                end
                if (dev_wdata[5] || !dev_wdata[7]) begin
                    {act_q, rxf_q} <= 2'b00;
                end
                if (dev_wdata[6] && dev_wdata[7]) begin
                    {act_q, first_q} <= 2'b11;
                    rx_n <= 8'h00;
                    cnt <= 12;
                end
            end
        end
    end
endmodule // i2c_dev_model
`default_nettype wire

// file: testbench/i2c_seq_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_seq_host_tb
    import i2c_seq_pkg::*;
;
    typedef struct packed {logic ten; logic is_rd; logic [9:0] sa; logic [7:0] len;} row_t;
    row_t rows[5] = '{'{1'b0, 1'b0, 10'h052, 8'h03}, '{1'b1, 1'b0, 10'h2a7, 8'h02},
                      '{1'b0, 1'b1, 10'h01d, 8'h01}, '{1'b0, 1'b1, 10'h033, 8'h03},
                      '{1'b0, 1'b0, 10'h07f, 8'h08}};
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        slow = 1'b0;
    logic [3:0]  nak_at = 4'h0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, v;
    logic [11:0] dev_addr;
    logic [7:0]  dev_wdata, dev_rdata;
    logic        dev_wr, dev_rd;
    logic [7:0]  exp_q[$];
    int          fail_count = 0;
    int          num_checks = 0;
    always #12.5 mclk = ~mclk;
    i2c_seq_host u_i2c_seq_host (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
        .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
    i2c_dev_model u_i2c_dev_model (.mclk(mclk), .sys_rst(sys_rst), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
        .slow(slow), .nak_at(nak_at));
    task automatic sw_write(input logic [7:0] a, input logic [15:0] x);
        @(posedge mclk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [7:0] a, output logic [15:0] x);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic start_job(input row_t r);
        u_i2c_dev_model.tx_q.delete();
        for (int i = 0; i < r.len; i++) sw_write(REG_BUF + 8'(i), 16'(8'h20 + i));
        sw_write(REG_SLAVE, {6'h00, r.sa});
        sw_write(REG_LEN, {8'h00, r.len});
        sw_write(REG_CMD, {13'h0000, r.ten, r.is_rd, 1'b1});
    endtask
    task automatic wait_done;
        v = 16'h0000;
        // Polling is bounded so a stuck sequencer ends in a mismatch, not a hang.
        for (int i = 0; i < 3000 && v[1] !== 1'b1; i++) sw_read(REG_STAT, v);
        chk("done flag", 16'h0002, {14'h0000, v[1:0]});
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 chk("rdata at reset", 16'h0000, rdata);
        chk("dev_wr at reset", 16'h0000, {15'h0000, dev_wr});
        sw_read(REG_STAT, v);
        chk("status at reset", 16'h0000, v);
        sw_read(8'h07, v);
        chk("unmapped read", 16'h0000, v);
        $display("test reset done");
        for (int r = 0; r < 5; r++) begin
            start_job(rows[r]);
            wait_done();
            exp_q.delete();
            if (rows[r].ten) begin
                exp_q.push_back({TEN_PREFIX, rows[r].sa[9:8], 1'b0});
                exp_q.push_back(rows[r].sa[7:0]);
            end else exp_q.push_back({rows[r].sa[6:0], rows[r].is_rd});
            for (int i = 0; i < rows[r].len && !rows[r].is_rd; i++) exp_q.push_back(8'h20 + 8'(i));
            chk("bytes sent", 16'(exp_q.size()), 16'(u_i2c_dev_model.tx_q.size()));
            foreach (exp_q[k]) chk("bus byte", 16'(exp_q[k]), 16'(u_i2c_dev_model.tx_q[k]));
            chk("last control", 16'h00a0, 16'(u_i2c_dev_model.last_ctl));
            if (rows[r].is_rd) chk("nack seen", 16'h0004, v & 16'h0004);
            for (int i = 0; i < rows[r].len && rows[r].is_rd; i++) begin
                sw_read(REG_BUF + 8'(i), v);
                chk("rx byte", 16'(8'h81 + i), {8'h00, v[7:0]});
            end
            $display("test row %0d done", r);
        end
        @(posedge mclk);
        slow <= 1'b1;
        nak_at <= 4'h2;
        start_job('{1'b0, 1'b0, 10'h044, 8'h03});
        sw_write(REG_SLAVE, 16'h0011);
        sw_write(REG_CMD, 16'h0001);
        wait_done();
        chk("nack seen", 16'h0004, v & 16'h0004);
        chk("bytes sent", 16'h0002, 16'(u_i2c_dev_model.tx_q.size()));
        chk("address byte", 16'h0088, 16'(u_i2c_dev_model.tx_q[0]));
        chk("last control", 16'h00a0, 16'(u_i2c_dev_model.last_ctl));
        $display("test slave nack done");
        slow <= 1'b0;
        nak_at <= 4'h0;
        start_job(rows[0]);
        repeat (30) @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        sw_read(REG_STAT, v);
        chk("status after reset", 16'h0000, v);
        $display("test mid reset done");
        give_verdict();
    end
endmodule // i2c_seq_host_tb
`default_nettype wire
